/* File: adcseq_top.sv */
// Conversion sequencer: APB registers, start and repeat control, result capture
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_map.svh"
module adcseq_top
	import adcseq_pkg::*;
#(
	parameter int RES_W = 10 // Converter result width
)(
	input wire logic clock_i, // 100 MHz clock
	input wire logic nrst_i, // Synchronous reset, active low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction
	input wire logic [11:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error on unmapped address
	input wire logic standby_i, // STOP or SLOW standby request
	input wire logic [RES_W-1:0] conv_data_i, // Result from analog core
	output logic conv_sample_o, // Pulse: core should start sampling
	output logic [2:0] channel_o, // Selected analog channel
	output logic input_gate_o, // Analog input gate, 1 disables
	output logic ladder_on_o, // Reference ladder connect
	output logic conversion_done_irq_o // One-cycle done pulse
);
	// Control and status state
	adcseq_state_e state, next_state;
	logic [7:0] converter_ctrl_one, next_ctrl_one;
	logic [7:0] converter_ctrl_two, next_ctrl_two;
	adcseq_result_s res, next_res;
	logic [11:0] cnt, next_cnt;
	logic [11:0] target;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_irq, next_sample;
	logic [2:0] next_channel;
	logic next_gate, next_ladder;
	logic sb1, sb2, sb3, standby, next_standby;
	logic acc, wr, rd, mapped;
	logic [1:0] mode;

	// Decode conversion time code into fc cycles, reserved codes use the shortest
	function automatic logic [11:0] adcseq_time(input logic [2:0] code);
		case (code)
			3'h2: adcseq_time = `ADCSEQ_T78;
			3'h3: adcseq_time = `ADCSEQ_T156;
			3'h4: adcseq_time = `ADCSEQ_T312;
			3'h5: adcseq_time = `ADCSEQ_T624;
			3'h6: adcseq_time = `ADCSEQ_T1248;
			default: adcseq_time = `ADCSEQ_T39;
		endcase
	endfunction : adcseq_time

	// Standby pin is asynchronous: three stages, change once the last two agree
	always_ff @(posedge clock_i)
	begin
		sb1 <= nrst_i ? standby_i : 1'b0;
		sb2 <= nrst_i ? sb1 : 1'b0;
		sb3 <= nrst_i ? sb2 : 1'b0;
		standby <= next_standby;
	end
	always_comb
	begin
		next_standby = standby;
		if (!nrst_i)
			next_standby = 1'b0;
		else if (sb2 == sb3)
			next_standby = sb3;
	end

	// APB strobes; ready gates the access so each transfer acts exactly once
	assign acc = psel_i && penable_i && pready_o;
	assign wr = acc && pwrite_i;
	assign rd = acc && !pwrite_i;
	assign mode = converter_ctrl_one[`ADCSEQ_C1_MODE_HI:`ADCSEQ_C1_MODE_LO];
	assign target = adcseq_time(converter_ctrl_two[`ADCSEQ_C2_TIME_HI:`ADCSEQ_C2_TIME_LO]);
	assign mapped = paddr_i == `ADCSEQ_OFF_CTRL_ONE || paddr_i == `ADCSEQ_OFF_CTRL_TWO ||
		paddr_i == `ADCSEQ_OFF_UPPER || paddr_i == `ADCSEQ_OFF_STATUS_WORD ||
		paddr_i == `ADCSEQ_OFF_STANDBY || paddr_i == `ADCSEQ_OFF_ANALOG;

	// Sequencer, control registers and result next-state
	always_comb
	begin
		next_state = state;
		next_ctrl_one = converter_ctrl_one;
		next_ctrl_two = converter_ctrl_two;
		next_res = res;
		next_cnt = cnt;
		next_irq = 1'b0;
		next_sample = 1'b0;
		if (wr && paddr_i == `ADCSEQ_OFF_CTRL_ONE)
			next_ctrl_one = pwdata_i[7:0];
		if (wr && paddr_i == `ADCSEQ_OFF_CTRL_TWO)
			next_ctrl_two = pwdata_i[7:0];
		// Upper result read clears done; a same-cycle completion below wins
		if (rd && paddr_i == `ADCSEQ_OFF_UPPER)
			next_res.done = 1'b0;
		case (state)
			ADCSEQ_IDLE:
			begin
				// Start on trigger in software or repeat mode
				if (converter_ctrl_one[`ADCSEQ_C1_TRIG] &&
					(mode == `ADCSEQ_MODE_SOFT || mode == `ADCSEQ_MODE_REPEAT))
				begin
					next_state = ADCSEQ_CONV;
					next_cnt = 12'h001;
					next_res.busy = 1'b1;
					next_res.done = 1'b0;
					next_sample = 1'b1;
					next_ctrl_one[`ADCSEQ_C1_TRIG] = 1'b0;
				end
			end
			ADCSEQ_CONV:
			begin
				next_cnt = cnt + 12'h001;
				if (mode == `ADCSEQ_MODE_OFF)
				begin
					// Halt at once, result discarded
					next_state = ADCSEQ_IDLE;
					next_res.busy = 1'b0;
				end
				else if (cnt >= target)
				begin
					// Result halves and done land together
					next_res.value = conv_data_i;
					next_res.done = 1'b1;
					next_irq = 1'b1;
					if (mode == `ADCSEQ_MODE_REPEAT)
					begin
						next_cnt = 12'h001;
						next_sample = 1'b1;
					end
					else
					begin
						next_state = ADCSEQ_IDLE;
						next_res.busy = 1'b0;
					end
				end
			end
			default: next_state = ADCSEQ_IDLE;
		endcase
		// Standby aborts and initialises both control registers
		if (standby)
		begin
			next_state = ADCSEQ_IDLE;
			next_ctrl_one = `ADCSEQ_C1_RESET;
			next_ctrl_two = `ADCSEQ_C2_RESET;
			next_res = '{value: `ADCSEQ_RES_RESET, done: 1'b0, busy: 1'b0};
			next_irq = 1'b0;
			next_sample = 1'b0;
		end
		if (!nrst_i)
		begin
			next_state = ADCSEQ_IDLE;
			next_ctrl_one = `ADCSEQ_C1_RESET;
			next_ctrl_two = `ADCSEQ_C2_RESET;
			next_res = '{value: `ADCSEQ_RES_RESET, done: 1'b0, busy: 1'b0};
			next_cnt = 12'h000;
			next_irq = 1'b0;
			next_sample = 1'b0;
		end
	end

	// Analog side outputs, registered
	always_comb
	begin
		next_channel = converter_ctrl_one[2:0];
		next_gate = converter_ctrl_one[`ADCSEQ_C1_GATE];
		// Out-of-range channel codes mapped to last input
		if (converter_ctrl_one[`ADCSEQ_C1_CH_HI:`ADCSEQ_C1_CH_LO] > `ADCSEQ_CH_MAX)
			next_channel = 3'(`ADCSEQ_CH_MAX);
		next_ladder = !standby && (converter_ctrl_two[`ADCSEQ_C2_LADDER] ||
			next_state == ADCSEQ_CONV);
		if (!nrst_i)
		begin
			next_channel = 3'h0;
			next_gate = 1'b1;
			next_ladder = 1'b0;
		end
	end

	// APB answer: no wait state, ready high for the one access cycle
	always_comb
	begin
		next_pready = psel_i && !penable_i;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (psel_i && !penable_i)
		begin
			next_pslverr = !mapped;
			case (paddr_i)
				`ADCSEQ_OFF_CTRL_ONE: next_prdata = {24'h00_0000, converter_ctrl_one};
				`ADCSEQ_OFF_CTRL_TWO: next_prdata = {24'h00_0000, converter_ctrl_two};
				`ADCSEQ_OFF_UPPER: next_prdata = {24'h00_0000, res.value[9:2]};
				// Low nibble is don't-care; drive zero
				`ADCSEQ_OFF_STATUS_WORD: next_prdata = {24'h00_0000, res.value[1:0],
					res.done, res.busy, 4'h0};
				`ADCSEQ_OFF_STANDBY: next_prdata = {31'h0000_0000, standby};
				`ADCSEQ_OFF_ANALOG: next_prdata = {22'h00_0000, conv_data_i};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		if (!nrst_i)
		begin
			next_pready = 1'b0;
			next_pslverr = 1'b0;
		end
	end

	// Register all state except the standby synchronizer
	always_ff @(posedge clock_i)
	begin
		state <= next_state;
		converter_ctrl_one <= next_ctrl_one;
		converter_ctrl_two <= next_ctrl_two;
		res <= next_res;
		cnt <= next_cnt;
		conversion_done_irq_o <= next_irq;
		conv_sample_o <= next_sample;
		channel_o <= next_channel;
		input_gate_o <= next_gate;
		ladder_on_o <= next_ladder;
		prdata_o <= next_prdata;
		pready_o <= next_pready;
		pslverr_o <= next_pslverr;
	end

	// Interrupt only ever accompanies a set done flag
	AST_DONE_IRQ: assert property (@(posedge clock_i) disable iff (!nrst_i)
		conversion_done_irq_o |-> res.done)
		else $error("Interrupt without done flag");
	AST_TRIG_CLR: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$rose(res.busy) |-> !converter_ctrl_one[`ADCSEQ_C1_TRIG])
		else $error("Trigger not cleared at start");
	// A repeat restart keeps done high, together with the interrupt
	AST_BUSY_START: assert property (@(posedge clock_i) disable iff (!nrst_i)
		conv_sample_o |-> res.busy && res.done == conversion_done_irq_o)
		else $error("Start without busy");
	AST_TIME: assert property (@(posedge clock_i) disable iff (!nrst_i)
		conversion_done_irq_o |-> $past(cnt) >= $past(target))
		else $error("Result too early");
	AST_STANDBY: assert property (@(posedge clock_i) disable iff (!nrst_i)
		standby |=> !res.busy && converter_ctrl_one == `ADCSEQ_C1_RESET)
		else $error("Standby did not abort");
	AST_LADDER: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$past(standby) && standby |-> !ladder_on_o)
		else $error("Ladder on in standby");
	AST_HALT: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state == ADCSEQ_CONV && mode == `ADCSEQ_MODE_OFF |=> !res.busy && $stable(res.value))
		else $error("Halt stored a result");
	AST_RDCLR: assert property (@(posedge clock_i) disable iff (!nrst_i)
		rd && paddr_i == `ADCSEQ_OFF_UPPER && !next_irq |=> !res.done)
		else $error("Upper read kept done");
	// Sequencing checks: start, completion, restart and hold of the result
	AST_START: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state == ADCSEQ_IDLE && converter_ctrl_one[`ADCSEQ_C1_TRIG] && !standby &&
		mode == `ADCSEQ_MODE_SOFT |=> conv_sample_o && res.busy && state == ADCSEQ_CONV)
		else $error("Software start missed");
	AST_SOFT_DONE: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state == ADCSEQ_CONV && cnt >= target && mode == `ADCSEQ_MODE_SOFT && !standby |=>
		state == ADCSEQ_IDLE && res.done && conversion_done_irq_o)
		else $error("Single conversion did not complete");
	AST_REPEAT_NEXT: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state == ADCSEQ_CONV && cnt >= target && mode == `ADCSEQ_MODE_REPEAT && !standby |=>
		conv_sample_o && res.busy && res.done)
		else $error("Repeat did not restart");
	AST_IDLE_FREE: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state == ADCSEQ_IDLE |-> !res.busy)
		else $error("Busy while idle");
	// Result moves only at completion, standby or reset
	AST_RESULT_HOLD: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$changed(res.value) |-> conversion_done_irq_o || $past(standby) || !$past(nrst_i))
		else $error("Result changed between completions");
	AST_LADDER_CONV: assert property (@(posedge clock_i) disable iff (!nrst_i)
		res.busy |-> ladder_on_o)
		else $error("Ladder off during conversion");
	AST_STANDBY_QUIET: assert property (@(posedge clock_i) disable iff (!nrst_i)
		standby |=> !conv_sample_o && !conversion_done_irq_o && state == ADCSEQ_IDLE)
		else $error("Conversion resumed in standby");
endmodule : adcseq_top
`default_nettype wire

/* File: adcseq_map.svh */
// Register offsets, field positions, reset values and timing codes of the conversion sequencer
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH
`define ADCSEQ_OFF_CTRL_ONE 12'h01C
`define ADCSEQ_OFF_CTRL_TWO 12'h020
`define ADCSEQ_OFF_UPPER 12'h024
`define ADCSEQ_OFF_STATUS 12'h01E
`define ADCSEQ_OFF_STATUS_WORD 12'h078
`define ADCSEQ_OFF_STANDBY 12'h028
`define ADCSEQ_OFF_ANALOG 12'h02C
`define ADCSEQ_C1_TRIG 7
`define ADCSEQ_C1_MODE_HI 6
`define ADCSEQ_C1_MODE_LO 5
`define ADCSEQ_C1_GATE 4
`define ADCSEQ_C1_CH_HI 3
`define ADCSEQ_C1_CH_LO 0
`define ADCSEQ_C2_LADDER 5
`define ADCSEQ_C2_TIME_HI 3
`define ADCSEQ_C2_TIME_LO 1
`define ADCSEQ_C1_RESET 8'h10
`define ADCSEQ_C2_RESET 8'h10
`define ADCSEQ_RES_RESET 10'h000
`define ADCSEQ_MODE_OFF 2'h0
`define ADCSEQ_MODE_SOFT 2'h1
`define ADCSEQ_MODE_REPEAT 2'h3
`define ADCSEQ_T39 12'h027
`define ADCSEQ_T78 12'h04E
`define ADCSEQ_T156 12'h09C
`define ADCSEQ_T312 12'h138
`define ADCSEQ_T624 12'h270
`define ADCSEQ_T1248 12'h4E0
`define ADCSEQ_CH_MAX 4'h7
`endif

/* File: adcseq_pkg.sv */
// Types shared by the conversion sequencer
package adcseq_pkg;
	typedef enum logic [0:0] {
		ADCSEQ_IDLE = 1'b0,
		ADCSEQ_CONV = 1'b1
	} adcseq_state_e;
	typedef struct packed {
		logic [9:0] value;
		logic done;
		logic busy;
	} adcseq_result_s;
endpackage : adcseq_pkg

/* File: adcseq_analog_model.sv */
// Analog input model: selected channel and a running sample count
`timescale 1ns/1ps
`default_nettype none
module adcseq_analog_model (
	input wire logic clock_i, // 100 MHz clock
	input wire logic sample_i, // Start of a conversion
	input wire logic [2:0] channel_i, // Selected input
	output logic [9:0] data_o // Value of the input
);
	logic [6:0] count = 7'h00;
	// Count starts so that no two results look alike
	always @(posedge clock_i)
		if (sample_i)
			count <= count + 7'h01;
	// Value only moves at a start or a channel change, so no other pin activity disturbs it
	assign data_o = {channel_i, count};
endmodule : adcseq_analog_model
`default_nettype wire

/* File: adc_conversion_sequencer_test.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_map.svh"
module adc_conversion_sequencer_test;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, standby = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, keep;
	logic pready, pslverr, sample, gate, ladder, irq;
	logic [2:0] chan;
	logic [9:0] data;
	int failures = 0;
	int tests_run = 0;
	int n;
	always #5 clock_i = ~clock_i;
	adcseq_top u_adcseq_top (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .standby_i(standby),
		.conv_data_i(data), .conv_sample_o(sample), .channel_o(chan), .input_gate_o(gate),
		.ladder_on_o(ladder), .conversion_done_irq_o(irq));
	adcseq_analog_model u_adcseq_analog_model (.clock_i(clock_i), .sample_i(sample),
		.channel_i(chan), .data_o(data));
	task end_sim;
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// One APB transfer; the request holds until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			failures++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so the next setup never reassigns psel in this time step
		@(posedge clock_i);
	endtask : apb
	// Bounded wait for the done pulse; n ends as cycles since the last edge
	task wait_irq;
		n = 0;
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (irq !== 1'b1 && n < 3000);
		if (n >= 3000)
		begin
			failures++;
			end_sim();
		end
	endtask : wait_irq
	task test_reset;
		apb(1'b0, `ADCSEQ_OFF_CTRL_ONE, 32'h0);
		check(rd, 32'h0000_0010);
		apb(1'b0, `ADCSEQ_OFF_CTRL_TWO, 32'h0);
		check(rd, 32'h0000_0010);
		apb(1'b0, `ADCSEQ_OFF_STATUS_WORD, 32'h0);
		check(rd[7:4], 4'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0000_0000);
		check(ladder, 1'b0);
		check(gate, 1'b1);
	endtask : test_reset
	task test_single;
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_0023);
		apb(1'b1, `ADCSEQ_OFF_CTRL_TWO, 32'h0000_0010);
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_00A3);
		wait_irq();
		// Start lands one edge after the write, the edge at which apb returns
		check(n, `ADCSEQ_T39 + 1);
		check(chan, 3'h3);
		check(gate, 1'b0);
		apb(1'b0, `ADCSEQ_OFF_STATUS_WORD, 32'h0);
		check(rd[7:4], 4'h6);
		apb(1'b0, `ADCSEQ_OFF_UPPER, 32'h0);
		check(rd, 32'h0000_0060);
		apb(1'b0, `ADCSEQ_OFF_STATUS_WORD, 32'h0);
		check(rd[7:4], 4'h4);
		apb(1'b1, `ADCSEQ_OFF_CTRL_TWO, 32'h0000_0014);
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_00A3);
		apb(1'b0, `ADCSEQ_OFF_CTRL_ONE, 32'h0);
		check(rd[7], 1'b0);
		apb(1'b0, `ADCSEQ_OFF_STATUS_WORD, 32'h0);
		check(rd[7:4], 4'h5);
		check(ladder, 1'b1);
		wait_irq();
		// Restart before reading: done drops, older result stays
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_00A3);
		apb(1'b0, `ADCSEQ_OFF_STATUS_WORD, 32'h0);
		check(rd[7:4], 4'h9);
		wait_irq();
		@(posedge clock_i);
		check(ladder, 1'b0);
	endtask : test_single
	task test_repeat;
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_0065);
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_00E5);
		wait_irq();
		wait_irq();
		apb(1'b0, `ADCSEQ_OFF_STATUS_WORD, 32'h0);
		check(rd[4], 1'b1);
		apb(1'b0, `ADCSEQ_OFF_UPPER, 32'h0);
		keep = rd;
		check(rd[7:5], 3'h5);
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_0005);
		apb(1'b0, `ADCSEQ_OFF_STATUS_WORD, 32'h0);
		check(rd[4], 1'b0);
		repeat (200) @(posedge clock_i);
		apb(1'b0, `ADCSEQ_OFF_UPPER, 32'h0);
		check(rd, keep);
		// Reserved channel code, converter off
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_000C);
		@(posedge clock_i);
		check(chan, 3'h7);
	endtask : test_repeat
	task test_standby;
		apb(1'b1, `ADCSEQ_OFF_CTRL_TWO, 32'h0000_0030);
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_0023);
		apb(1'b1, `ADCSEQ_OFF_CTRL_ONE, 32'h0000_00A3);
		standby <= 1'b1;
		repeat (6) @(posedge clock_i);
		check(ladder, 1'b0);
		apb(1'b0, `ADCSEQ_OFF_CTRL_ONE, 32'h0);
		check(rd, 32'h0000_0010);
		apb(1'b0, `ADCSEQ_OFF_CTRL_TWO, 32'h0);
		check(rd, 32'h0000_0010);
		apb(1'b0, `ADCSEQ_OFF_STATUS_WORD, 32'h0);
		check(rd[4], 1'b0);
		standby <= 1'b0;
		repeat (100) @(posedge clock_i);
		apb(1'b0, `ADCSEQ_OFF_STATUS_WORD, 32'h0);
		check(rd[4], 1'b0);
	endtask : test_standby
	// Reset, then each scenario in turn
	initial
	begin
		repeat (6) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(posedge clock_i);
		test_reset();
		test_single();
		test_repeat();
		test_standby();
		end_sim();
	end
endmodule : adc_conversion_sequencer_test
`default_nettype wire
